// [verilog/lfr_pkg.sv]
// Constants, types and register map of the fault and restart sequencer
package lfr_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 125;
	localparam int SENSE_US = 500;
	localparam int SENSE_CYC = SENSE_US * CLK_MHZ;
	localparam int CS_MIN_NS = 30;
	localparam int CS_FILT_CYC = (CS_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam logic [2:0] CS_FILT_CNT = 3'(CS_FILT_CYC);
	localparam int SHORT_WAIT_CYC = 1024;
	localparam int LONG_WAIT_CYC = 131072;
	localparam logic [2:0] OC_TRIP_CNT = 3'h7;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_FAULT = 12'h008;
	localparam logic CTRL_OFF_RST = 1'h0;
	localparam int CTRL_OFF_BIT = 0;
	localparam int FLT_OC = 0;
	localparam int FLT_SHORT = 1;
	localparam int FLT_LINE = 2;
	localparam int FLT_VCC = 3;
	localparam int FLT_OTP = 4;
	localparam int FLT_REMOTE = 5;
	localparam int FLT_W = 6;

	// ****************************************
	// Burst threshold fractions, in eighths of the start frequency
	// ****************************************
	localparam logic [2:0][3:0] BURST_UP_NUM = {4'h5, 4'h6, 4'h7};
	localparam logic [2:0][3:0] BURST_LO_NUM = {4'h4, 4'h5, 4'h6};
	localparam logic [1:0] BURST_SEL_MAX = 2'h2;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_WAIT = 4'h2,
		ST_RUN = 4'h4,
		ST_LATCH = 4'h8
	} lfr_state_t;

	typedef struct packed {
		logic vcc_above_start;
		logic vcc_above_shutdown;
		logic hs_supply_ok;
		logic line_above_brownin;
		logic line_above_brownout;
		logic line_above_ov;
		logic line_below_ov_restart;
		logic line_grounded;
		logic cs_above_low;
		logic cs_above_high;
		logic otp_hot;
		logic osc_clk;
		logic sw_cycle_end;
		logic [1:0] burst_ratio;
		logic [7:0] max_start_frequency_code;
		logic [7:0] cmd_freq;
	} lfr_ana_t;

	typedef struct packed {
		lfr_ana_t s1;
		lfr_ana_t s2;
		lfr_ana_t s3;
		lfr_ana_t q;
	} lfr_sync_t;

	typedef struct packed {
		lfr_state_t state;
		logic vcc_on;
		logic [15:0] sense_cnt;
		logic sense_done;
		logic [1:0] burst_sel;
		logic [7:0] burst_up;
		logic [7:0] burst_lo;
		logic [7:0] max_start_frequency_set;
		logic burst_stop;
		logic [17:0] wait_cnt;
		logic wait_long;
		logic first_pending;
		logic osc_prev;
		logic cyc_prev;
		logic [2:0] cnt_low;
		logic [2:0] cnt_high;
		logic pk_low;
		logic [2:0] oc_cnt;
		logic line_good;
		logic ov_lock;
		logic max_start_frequency_start;
		logic hs_seen_low;
		logic ctrl_off;
		logic [FLT_W-1:0] fault;
		logic [31:0] prdata;
	} lfr_regs_t;
endpackage : lfr_pkg

// [verilog/lfr_sync.sv]
// Three-stage synchroniser for the digitised analog indications
`timescale 1ns/10ps
module lfr_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire lfr_pkg::lfr_ana_t d,
	output lfr_pkg::lfr_ana_t q
);
	lfr_pkg::lfr_sync_t st_ff;
	lfr_pkg::lfr_sync_t nxt_st;

	// ****************************************
	// Shift chain; output follows once stages two and three agree
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.q = lfr_pkg::lfr_ana_t'((st_ff.s2 & st_ff.s3) | (st_ff.q & (st_ff.s2 | st_ff.s3)));
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.q;
endmodule : lfr_sync

// [verilog/lfr_sequencer.sv]
// Start-up, fault and auto-restart sequencer with APB status and control
`timescale 1ns/10ps
module lfr_sequencer #(
	parameter logic [17:0] LONG_WAIT_CYC_P = 18'(lfr_pkg::LONG_WAIT_CYC),
	parameter logic [15:0] SENSE_CYC_P = 16'(lfr_pkg::SENSE_CYC)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire lfr_pkg::lfr_ana_t ana_in,
	output logic fb_pullup_on,
	output logic switch_enable,
	output logic hs_drive_enable,
	output logic start_at_max_start_frequency,
	output logic dt_sense_mode,
	output logic [1:0] burst_sel,
	output logic [7:0] burst_upper,
	output logic [7:0] burst_lower,
	output logic [7:0] max_start_frequency_setting
);
	lfr_pkg::lfr_regs_t st_ff;
	lfr_pkg::lfr_regs_t nxt_st;
	lfr_pkg::lfr_ana_t a;
	logic nxt_vcc_on;
	logic vcc_rise;
	logic osc_edge;
	logic cyc_end;
	logic cs_low_hit;
	logic cs_high_hit;
	logic peak_seen;
	logic oc_trip;
	logic remote_off;
	logic run_fault;
	logic in_run;
	logic wait_hold;
	logic [17:0] wait_lim;
	logic [11:0] up_prod;
	logic [11:0] lo_prod;
	logic apb_setup;
	logic apb_access;
	logic apb_mapped;
	logic [31:0] rd_mux;
	logic [lfr_pkg::FLT_W-1:0] flt_set;
	logic [lfr_pkg::FLT_W-1:0] flt_clr;

	// ****************************************
	// Input synchroniser
	// ****************************************
	lfr_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(ana_in),
		.q(a)
	);

	// ****************************************
	// Event and qualifier terms
	// ****************************************
	// Logic supply hysteresis: on at start level, off at shutdown level
	assign nxt_vcc_on = a.vcc_above_start | (st_ff.vcc_on & a.vcc_above_shutdown);
	assign vcc_rise = nxt_vcc_on & ~st_ff.vcc_on;
	assign osc_edge = a.osc_clk & ~st_ff.osc_prev;
	assign cyc_end = a.sw_cycle_end & ~st_ff.cyc_prev;
	assign in_run = (st_ff.state == lfr_pkg::ST_RUN);

	// Crossing qualifies on the fourth consecutive cycle above threshold
	assign cs_low_hit = a.cs_above_low & (st_ff.cnt_low == lfr_pkg::CS_FILT_CNT - 3'h1);
	assign cs_high_hit = a.cs_above_high & (st_ff.cnt_high == lfr_pkg::CS_FILT_CNT - 3'h1);
	assign peak_seen = st_ff.pk_low | cs_low_hit;
	assign oc_trip = in_run & cyc_end & peak_seen & (st_ff.oc_cnt == lfr_pkg::OC_TRIP_CNT - 3'h1);

	// Remote-off sources force the long wait
	assign remote_off = a.line_grounded | st_ff.ctrl_off | cs_high_hit;
	assign run_fault = oc_trip | remote_off | ~st_ff.line_good;
	assign wait_hold = remote_off | ~st_ff.line_good | ~st_ff.sense_done;
	assign wait_lim = st_ff.wait_long ? LONG_WAIT_CYC_P : 18'(lfr_pkg::SHORT_WAIT_CYC);

	// Burst thresholds as eighths of the start frequency
	always_comb begin
		case (st_ff.burst_sel)
			2'h0: begin
				up_prod = st_ff.max_start_frequency_set * lfr_pkg::BURST_UP_NUM[0];
				lo_prod = st_ff.max_start_frequency_set * lfr_pkg::BURST_LO_NUM[0];
			end
			2'h1: begin
				up_prod = st_ff.max_start_frequency_set * lfr_pkg::BURST_UP_NUM[1];
				lo_prod = st_ff.max_start_frequency_set * lfr_pkg::BURST_LO_NUM[1];
			end
			default: begin
				up_prod = st_ff.max_start_frequency_set * lfr_pkg::BURST_UP_NUM[2];
				lo_prod = st_ff.max_start_frequency_set * lfr_pkg::BURST_LO_NUM[2];
			end
		endcase
	end

	// ****************************************
	// APB decode
	// ****************************************
	assign apb_setup = psel & ~penable;
	assign apb_access = psel & penable;
	assign apb_mapped = (paddr == lfr_pkg::OFS_CTRL) | (paddr == lfr_pkg::OFS_STATUS)
		| (paddr == lfr_pkg::OFS_FAULT);

	// Read multiplexer
	always_comb begin
		case (paddr)
			lfr_pkg::OFS_CTRL: rd_mux = {31'h0, st_ff.ctrl_off};
			lfr_pkg::OFS_STATUS: rd_mux = {19'h0, st_ff.first_pending, st_ff.line_good,
				st_ff.oc_cnt, st_ff.burst_stop, st_ff.sense_done, st_ff.burst_sel, st_ff.state};
			lfr_pkg::OFS_FAULT: rd_mux = {26'h0, st_ff.fault};
			default: rd_mux = 32'h0;
		endcase
	end

	// Fault causes seen by software; a new event wins over a clear
	always_comb begin
		flt_set = '0;
		flt_set[lfr_pkg::FLT_OC] = oc_trip;
		flt_set[lfr_pkg::FLT_SHORT] = in_run & cs_high_hit;
		flt_set[lfr_pkg::FLT_LINE] = in_run & ~st_ff.line_good & ~a.line_grounded;
		flt_set[lfr_pkg::FLT_VCC] = ~st_ff.vcc_on & (st_ff.state != lfr_pkg::ST_OFF);
		flt_set[lfr_pkg::FLT_OTP] = a.otp_hot & (st_ff.state != lfr_pkg::ST_LATCH)
			& (st_ff.state != lfr_pkg::ST_OFF);
		flt_set[lfr_pkg::FLT_REMOTE] = in_run & (a.line_grounded | st_ff.ctrl_off);
		flt_clr = (apb_access & pwrite & (paddr == lfr_pkg::OFS_FAULT))
			? pwdata[lfr_pkg::FLT_W-1:0] : '0;
	end

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.vcc_on = nxt_vcc_on;
		nxt_st.osc_prev = a.osc_clk;
		nxt_st.cyc_prev = a.sw_cycle_end;

		// Line window with hysteresis; overvoltage held until restart level
		if (a.line_above_ov) begin
			nxt_st.ov_lock = 1'b1;
		end else if (a.line_below_ov_restart) begin
			nxt_st.ov_lock = 1'b0;
		end
		if (a.line_grounded | nxt_st.ov_lock | ~a.line_above_brownout) begin
			nxt_st.line_good = 1'b0;
		end else if (a.line_above_brownin) begin
			nxt_st.line_good = 1'b1;
		end

		// Program input sensing window after each supply power-up
		if (vcc_rise) begin
			nxt_st.sense_cnt = 16'h0;
			nxt_st.sense_done = 1'b0;
		end else if (st_ff.vcc_on & ~st_ff.sense_done) begin
			if (st_ff.sense_cnt == SENSE_CYC_P - 16'h1) begin
				nxt_st.sense_done = 1'b1;
				// Choice held until next supply cycle
				nxt_st.burst_sel = (a.burst_ratio > lfr_pkg::BURST_SEL_MAX)
					? lfr_pkg::BURST_SEL_MAX : a.burst_ratio;
			end else begin
				nxt_st.sense_cnt = st_ff.sense_cnt + 16'h1;
			end
		end

		// Normal mode: start frequency setting tracks its input code
		if (st_ff.sense_done) begin
			nxt_st.max_start_frequency_set = a.max_start_frequency_code;
		end
		nxt_st.burst_up = up_prod[10:3];
		nxt_st.burst_lo = lo_prod[10:3];

		// Pulse width filters on both current thresholds
		if (!a.cs_above_low) begin
			nxt_st.cnt_low = 3'h0;
		end else if (st_ff.cnt_low != lfr_pkg::CS_FILT_CNT) begin
			nxt_st.cnt_low = st_ff.cnt_low + 3'h1;
		end
		if (!a.cs_above_high) begin
			nxt_st.cnt_high = 3'h0;
		end else if (st_ff.cnt_high != lfr_pkg::CS_FILT_CNT) begin
			nxt_st.cnt_high = st_ff.cnt_high + 3'h1;
		end
		nxt_st.pk_low = cyc_end ? 1'b0 : peak_seen;

		// Consecutive over-current cycle count
		if (in_run & cyc_end) begin
			nxt_st.oc_cnt = peak_seen ? st_ff.oc_cnt + 3'h1 : 3'h0;
		end

		// Burst hysteresis on the commanded frequency
		if (!in_run) begin
			nxt_st.burst_stop = 1'b0;
		end else if (a.cmd_freq > st_ff.burst_up) begin
			nxt_st.burst_stop = 1'b1;
		end else if (a.cmd_freq < st_ff.burst_lo) begin
			nxt_st.burst_stop = 1'b0;
		end

		// Sequencer
		case (st_ff.state)
			lfr_pkg::ST_OFF: begin
				nxt_st.wait_cnt = 18'h0;
				nxt_st.wait_long = 1'b0;
				nxt_st.first_pending = 1'b1;
				if (st_ff.vcc_on) begin
					nxt_st.state = lfr_pkg::ST_WAIT;
				end
			end
			lfr_pkg::ST_WAIT: begin
				nxt_st.oc_cnt = 3'h0;
				if (wait_hold) begin
					// Restart the wait; brown-in on first power-up keeps it short
					nxt_st.wait_cnt = 18'h0;
					if (remote_off | ~st_ff.first_pending) begin
						nxt_st.wait_long = 1'b1;
					end
				end else if (osc_edge) begin
					if (st_ff.wait_cnt == wait_lim - 18'h1) begin
						nxt_st.state = lfr_pkg::ST_RUN;
						nxt_st.wait_cnt = 18'h0;
						nxt_st.first_pending = 1'b0;
						nxt_st.max_start_frequency_start = 1'b1;
					end else begin
						nxt_st.wait_cnt = st_ff.wait_cnt + 18'h1;
					end
				end
			end
			lfr_pkg::ST_RUN: begin
				if (cyc_end) begin
					nxt_st.max_start_frequency_start = 1'b0;
				end
				if (run_fault) begin
					nxt_st.state = lfr_pkg::ST_WAIT;
					nxt_st.wait_long = 1'b1;
					nxt_st.wait_cnt = 18'h0;
					nxt_st.oc_cnt = 3'h0;
					nxt_st.max_start_frequency_start = 1'b0;
				end
			end
			lfr_pkg::ST_LATCH: begin
				// Leave only after a cool high-side supply cycle
				if (!a.hs_supply_ok & !a.otp_hot) begin
					nxt_st.hs_seen_low = 1'b1;
				end
				if (st_ff.hs_seen_low & a.hs_supply_ok & !a.otp_hot) begin
					nxt_st.state = lfr_pkg::ST_WAIT;
					nxt_st.wait_long = 1'b1;
					nxt_st.wait_cnt = 18'h0;
				end
			end
			default: begin
				nxt_st.state = lfr_pkg::ST_OFF;
			end
		endcase

		// Over-temperature latch overrides any running state
		if (a.otp_hot & (st_ff.state != lfr_pkg::ST_LATCH) & (st_ff.state != lfr_pkg::ST_OFF)) begin
			nxt_st.state = lfr_pkg::ST_LATCH;
			nxt_st.hs_seen_low = 1'b0;
			nxt_st.max_start_frequency_start = 1'b0;
		end
		// Supply lockout overrides everything
		if (!st_ff.vcc_on) begin
			nxt_st.state = lfr_pkg::ST_OFF;
			nxt_st.max_start_frequency_start = 1'b0;
		end

		// Register file
		if (apb_access & pwrite & (paddr == lfr_pkg::OFS_CTRL)) begin
			nxt_st.ctrl_off = pwdata[lfr_pkg::CTRL_OFF_BIT];
		end
		nxt_st.fault = (st_ff.fault & ~flt_clr) | flt_set;
		if (apb_setup & ~pwrite) begin
			nxt_st.prdata = rd_mux;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{state: lfr_pkg::ST_OFF, ctrl_off: lfr_pkg::CTRL_OFF_RST, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign fb_pullup_on = ~in_run;
	assign switch_enable = in_run & ~st_ff.burst_stop;
	assign hs_drive_enable = switch_enable & a.hs_supply_ok;
	assign start_at_max_start_frequency = in_run & st_ff.max_start_frequency_start;
	assign dt_sense_mode = st_ff.vcc_on & ~st_ff.sense_done;
	assign burst_sel = st_ff.burst_sel;
	assign burst_upper = st_ff.burst_up;
	assign burst_lower = st_ff.burst_lo;
	assign max_start_frequency_setting = st_ff.max_start_frequency_set;
	assign prdata = st_ff.prdata;
	assign pready = 1'b1;
	assign pslverr = apb_access & ~apb_mapped;

	// ****************************************
	// Assertions
	// ****************************************
	a_supply_off: assert property (@(posedge pclk) disable iff (!presetn)
		!st_ff.vcc_on |=> st_ff.state == lfr_pkg::ST_OFF)
		else $error("state not off after supply lockout");
	a_hs_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!a.hs_supply_ok |-> !hs_drive_enable)
		else $error("high-side drive with supply locked out");
	a_pullup_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!in_run |-> fb_pullup_on && !switch_enable)
		else $error("switching without start");
	a_sense_len: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(st_ff.sense_done) |-> $past(st_ff.sense_cnt) == SENSE_CYC_P - 16'h1)
		else $error("sensing window length wrong");
	a_burst_keep: assert property (@(posedge pclk) disable iff (!presetn)
		st_ff.sense_done && $past(st_ff.sense_done) |-> $stable(st_ff.burst_sel))
		else $error("burst setting changed");
	a_long_wait: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(in_run) && $past(st_ff.wait_long) |->
		$past(st_ff.wait_cnt) == LONG_WAIT_CYC_P - 18'h1)
		else $error("long wait length wrong");
	a_short_wait: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(in_run) && !$past(st_ff.wait_long) |->
		$past(st_ff.wait_cnt) == 18'(lfr_pkg::SHORT_WAIT_CYC) - 18'h1)
		else $error("short wait length wrong");
	a_oc_seven: assert property (@(posedge pclk) disable iff (!presetn)
		in_run && cyc_end && peak_seen && st_ff.oc_cnt == 3'h6 && st_ff.vcc_on && !a.otp_hot
		|=> st_ff.state == lfr_pkg::ST_WAIT && st_ff.oc_cnt == 3'h0)
		else $error("seventh over-current cycle missed");
	a_short_trip: assert property (@(posedge pclk) disable iff (!presetn)
		in_run && cs_high_hit && st_ff.vcc_on && !a.otp_hot
		|=> st_ff.state == lfr_pkg::ST_WAIT && st_ff.wait_long)
		else $error("short-circuit pulse missed");
	a_filter_len: assert property (@(posedge pclk) disable iff (!presetn)
		cs_low_hit |-> $past(a.cs_above_low, 1) && $past(a.cs_above_low, 2)
		&& $past(a.cs_above_low, 3))
		else $error("current pulse qualified too early");
	a_otp_latch: assert property (@(posedge pclk) disable iff (!presetn)
		a.otp_hot && st_ff.vcc_on && st_ff.state != lfr_pkg::ST_OFF
		|=> st_ff.state == lfr_pkg::ST_LATCH)
		else $error("over-temperature not latched");
	a_burst_stop: assert property (@(posedge pclk) disable iff (!presetn)
		in_run && a.cmd_freq > st_ff.burst_up && !run_fault && st_ff.vcc_on && !a.otp_hot
		|=> !switch_enable)
		else $error("burst stop missed");
	a_wait_restart: assert property (@(posedge pclk) disable iff (!presetn)
		st_ff.state == lfr_pkg::ST_WAIT && remote_off && st_ff.vcc_on && !a.otp_hot
		|=> st_ff.wait_cnt == 18'h0 && st_ff.wait_long)
		else $error("wait not restarted by fault");
endmodule : lfr_sequencer

// [bench/lfr_ana_model.sv]
// Behavioural model of the comparators, oscillator and switching cycle timing
`timescale 1ns/10ps
module lfr_ana_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire lfr_pkg::lfr_ana_t lev,
	input wire logic run,
	input wire logic cs_lo_en,
	input wire logic cs_hi_en,
	input wire logic [3:0] cs_w,
	output lfr_pkg::lfr_ana_t ana,
	output logic cyc_done
);
	logic [3:0] ph_ff;
	logic [2:0] osc_ff;
	logic pk;
	// Oscillator runs free; switching phase only advances while switching is enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_ff <= 4'h0;
			osc_ff <= 3'h0;
		end else begin
			osc_ff <= osc_ff + 3'h1;
			ph_ff <= run ? ph_ff + 4'h1 : 4'h0;
		end
	end
	// Current pulse early in each cycle, cycle end in the last quarter
	always_comb begin
		pk = ({1'b0, ph_ff} >= 5'h02) && ({1'b0, ph_ff} < 5'h02 + {1'b0, cs_w});
		ana = lev;
		ana.osc_clk = osc_ff[2];
		ana.sw_cycle_end = ph_ff >= 4'hc;
		ana.cs_above_low = (cs_lo_en | cs_hi_en) & pk;
		ana.cs_above_high = cs_hi_en & pk;
	end
	// Marks the edge at which a switching cycle ends
	assign cyc_done = ph_ff == 4'hc;
endmodule : lfr_ana_model

// [bench/tb.sv]
// Self-checking testbench of the fault and restart sequencer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
	localparam logic [11:0] A_CTRL = lfr_pkg::OFS_CTRL;
	localparam logic [11:0] A_STAT = lfr_pkg::OFS_STATUS;
	localparam logic [11:0] A_FLT = lfr_pkg::OFS_FAULT;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, cs_lo_en, cs_hi_en, cyc_done;
	logic fb_pullup_on, switch_enable, hs_drive_enable, start_at_max_start_frequency, dt_sense_mode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [1:0] burst_sel;
	logic [7:0] burst_upper, burst_lower, max_start_frequency_setting;
	logic [3:0] cs_w;
	lfr_pkg::lfr_ana_t lev, ana_in;
	int failures, samples_checked, n, tick;
	// Design with shortened long wait and sensing window
	lfr_sequencer #(.LONG_WAIT_CYC_P(18'h28), .SENSE_CYC_P(16'h14)) u_lfr_sequencer (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ana_in(ana_in), .fb_pullup_on(fb_pullup_on), .switch_enable(switch_enable),
		.hs_drive_enable(hs_drive_enable), .start_at_max_start_frequency(start_at_max_start_frequency),
		.dt_sense_mode(dt_sense_mode), .burst_sel(burst_sel), .burst_upper(burst_upper),
		.burst_lower(burst_lower), .max_start_frequency_setting(max_start_frequency_setting));
	// Far side model
	lfr_ana_model u_lfr_ana_model (.pclk(pclk), .presetn(presetn), .lev(lev),
		.run(switch_enable), .cs_lo_en(cs_lo_en), .cs_hi_en(cs_hi_en), .cs_w(cs_w),
		.ana(ana_in), .cyc_done(cyc_done));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Hang guard
	always @(posedge pclk) begin
		tick++;
		if (tick == 40000) begin
			failures++;
			complete_run();
		end
	end
	// Verdict and end of run
	task complete_run();
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	// One APB transfer; read data and error land in d and err
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Access phase lasts until ready; only the hang guard ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		d = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic step(input int k);
		repeat (k) @(posedge pclk);
	endtask : step
	// Waits for switching to start and checks the time it took
	task automatic run_in(input int lo, input int hi);
		n = 0;
		while (switch_enable !== 1'b1 && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		`CHK("restart_time", 1'b1, (n >= lo && n <= hi))
	endtask : run_in
	// Drives current pulses over k events, each a switching cycle end or a fall of switching
	task automatic cycles(input int k, input logic lo, input logic hi, input logic [3:0] w);
		@(posedge cyc_done);
		cs_lo_en <= lo;
		cs_hi_en <= hi;
		cs_w <= w;
		repeat (k) @(posedge cyc_done or negedge switch_enable);
		cs_lo_en <= 1'b0;
		cs_hi_en <= 1'b0;
		step(6);
	endtask : cycles
	// Main sequence
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{cs_lo_en, cs_hi_en, failures, samples_checked, tick} = '0;
		cs_w = 4'h8;
		lev = '0;
		lev.hs_supply_ok = 1'b1;
		{lev.line_above_brownin, lev.line_above_brownout, lev.line_below_ov_restart} = 3'h7;
		lev.max_start_frequency_code = 8'h80;
		lev.burst_ratio = 2'h1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		step(10);
		@(negedge pclk);
		`CHK("pullup_off_state", 1'b1, fb_pullup_on)
		`CHK("switch_off_state", 1'b0, switch_enable)
		apb(1'b0, A_CTRL, 32'h0);
		`CHK("ctrl_reset", 32'h0, d)
		apb(1'b0, A_STAT, 32'h0);
		`CHK("state_off", 4'h1, d[3:0])
		apb(1'b0, 12'h0f0, 32'h0);
		`CHK("unmapped_err", 1'b1, err)
		lev.vcc_above_start <= 1'b1;
		lev.vcc_above_shutdown <= 1'b1;
		step(8);
		@(negedge pclk);
		`CHK("sense_mode", 1'b1, dt_sense_mode)
		run_in(8000, 8700);
		@(negedge pclk);
		`CHK("start_max_start_frequency", 1'b1, start_at_max_start_frequency)
		`CHK("pullup_released", 1'b0, fb_pullup_on)
		`CHK("sense_over", 1'b0, dt_sense_mode)
		`CHK("burst_sel", 2'h1, burst_sel)
		`CHK("burst_up", 8'h60, burst_upper)
		`CHK("burst_lo", 8'h50, burst_lower)
		@(posedge pclk);
		lev.burst_ratio <= 2'h2;
		lev.max_start_frequency_code <= 8'h40;
		step(10);
		@(negedge pclk);
		`CHK("burst_sel_kept", 2'h1, burst_sel)
		`CHK("max_start_frequency_follow", 8'h40, max_start_frequency_setting)
		`CHK("burst_up_follow", 8'h30, burst_upper)
		@(posedge pclk);
		lev.cmd_freq <= 8'h38;
		step(10);
		@(negedge pclk);
		`CHK("burst_stop", 1'b0, switch_enable)
		lev.cmd_freq <= 8'h2c;
		step(10);
		@(negedge pclk);
		`CHK("burst_hyst", 1'b0, switch_enable)
		lev.cmd_freq <= 8'h10;
		lev.hs_supply_ok <= 1'b0;
		step(10);
		@(negedge pclk);
		`CHK("burst_resume", 1'b1, switch_enable)
		`CHK("hs_lockout", 1'b0, hs_drive_enable)
		lev.hs_supply_ok <= 1'b1;
		cycles(6, 1'b1, 1'b0, 4'h8);
		apb(1'b0, A_STAT, 32'h0);
		`CHK("oc_count6", 3'h6, d[10:8])
		`CHK("still_run", 4'h4, d[3:0])
		cycles(1, 1'b0, 1'b0, 4'h8);
		apb(1'b0, A_STAT, 32'h0);
		`CHK("oc_clear", 3'h0, d[10:8])
		cycles(7, 1'b1, 1'b0, 4'h8);
		apb(1'b0, A_FLT, 32'h0);
		`CHK("oc_fault", 1'b1, d[lfr_pkg::FLT_OC])
		apb(1'b1, A_FLT, 32'h3f);
		run_in(200, 400);
		apb(1'b0, A_STAT, 32'h0);
		`CHK("oc_restart_clr", 7'h04, {d[10:8], d[3:0]})
		cycles(3, 1'b1, 1'b1, 4'h2);
		apb(1'b0, A_STAT, 32'h0);
		`CHK("narrow_ignored", 4'h4, d[3:0])
		cycles(1, 1'b1, 1'b1, 4'h8);
		apb(1'b0, A_FLT, 32'h0);
		`CHK("short_fault", 1'b1, d[lfr_pkg::FLT_SHORT])
		apb(1'b1, A_FLT, 32'h3f);
		run_in(200, 400);
		lev.line_grounded <= 1'b1;
		step(10);
		@(negedge pclk);
		`CHK("remote_pullup", 1'b1, fb_pullup_on)
		lev.line_grounded <= 1'b0;
		step(200);
		@(negedge pclk);
		`CHK("still_waiting", 1'b0, switch_enable)
		lev.line_grounded <= 1'b1;
		step(10);
		lev.line_grounded <= 1'b0;
		run_in(300, 400);
		apb(1'b0, A_FLT, 32'h0);
		`CHK("remote_fault", 1'b1, d[lfr_pkg::FLT_REMOTE])
		apb(1'b1, A_CTRL, 32'h1);
		step(6);
		apb(1'b0, A_STAT, 32'h0);
		`CHK("force_off_wait", 4'h2, d[3:0])
		apb(1'b1, A_CTRL, 32'h0);
		run_in(300, 400);
		lev.line_above_ov <= 1'b1;
		lev.line_below_ov_restart <= 1'b0;
		step(10);
		apb(1'b0, A_FLT, 32'h0);
		`CHK("ov_fault", 1'b1, d[lfr_pkg::FLT_LINE])
		lev.line_above_ov <= 1'b0;
		lev.line_below_ov_restart <= 1'b1;
		run_in(300, 400);
		lev.otp_hot <= 1'b1;
		step(10);
		apb(1'b0, A_STAT, 32'h0);
		`CHK("otp_latch", 4'h8, d[3:0])
		lev.otp_hot <= 1'b0;
		step(400);
		@(negedge pclk);
		`CHK("otp_held", 1'b0, switch_enable)
		lev.hs_supply_ok <= 1'b0;
		step(10);
		lev.hs_supply_ok <= 1'b1;
		run_in(300, 400);
		lev.vcc_above_start <= 1'b0;
		step(10);
		@(negedge pclk);
		`CHK("vcc_hyst", 1'b1, switch_enable)
		lev.vcc_above_shutdown <= 1'b0;
		step(10);
		@(negedge pclk);
		`CHK("vcc_shutdown", 1'b1, fb_pullup_on)
		lev.vcc_above_start <= 1'b1;
		lev.vcc_above_shutdown <= 1'b1;
		run_in(8000, 8700);
		@(negedge pclk);
		`CHK("burst_resel", 2'h2, burst_sel)
		`CHK("burst_up_sel2", 8'h28, burst_upper)
		`CHK("burst_lo_sel2", 8'h20, burst_lower)
		complete_run();
	end
endmodule : tb
